// *** rtl/ct_capture_timer.sv ***
// capture timer core: output stage, noise filter, companion clocking,
// event strobe, interrupt, sleep gating and byte-wide register file
// assumes sleep/debug/companion inputs come from logic on aclk
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps

// Function
// [RULE1] unsynced select 0 updates output with timer clock, 1 acts on event
// [RULE2] single-shot synchronous: output high when counter starts, low on stop
// [RULE3] single-shot unsynced: output high on trigger event, low on stop
// [RULE4] other modes output initial level bit; 8-bit PWM mode outputs waveform
// [RULE5] filter keeps four samples, passes level after four equal samples
// [RULE6] enabled filter adds four system clock cycles of latency
// [RULE7] filter samples on undivided system clock, ignores prescaler
// [RULE8] companion clock source advances counter on companion ticks
// [RULE9] restart-with-companion restarts counter when companion restarts
// [RULE10] each capture flag set gives a one-cycle event output strobe
// [RULE11] one event input, acts by edge bit only when input enabled
// [RULE12] single-shot event input is edge triggered
// [RULE13] outside single-shot the source holds events one clock at least
// [RULE14] interrupt condition sets capture flag regardless of enable
// [RULE15] interrupt request equals enable and capture flag
// [RULE16] interrupt request stays active until flag is cleared
// [RULE17] timer halts completely in power-down sleep; code still clears the counter on events and restarts and captures on events
// [RULE18] standby halts timer unless run-in-standby is set
// [RULE19] clock codes: 0 peripheral, 1 peripheral/2, 2 companion clock
// [RULE20] run-in-standby ignored when companion clock selected
// [RULE21] output enable 0 holds output zero, 1 gives mode value
// [RULE22] 16-bit registers go through staging byte, low byte first
module ct_capture_timer
  import ct_pkg::*;
(
  input  wire logic              aclk,            // system clock
  input  wire logic              aresetn,         // sync reset, low
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,    // write address
  input  wire logic              s_axi_awvalid,   // write addr valid
  output logic                   s_axi_awready,   // write addr taken
  input  wire logic [AXI_DW-1:0] s_axi_wdata,     // write data
  input  wire logic [3:0]        s_axi_wstrb,     // byte enables
  input  wire logic              s_axi_wvalid,    // write data valid
  output logic                   s_axi_wready,    // write data taken
  output logic [1:0]             s_axi_bresp,     // write response
  output logic                   s_axi_bvalid,    // response valid
  input  wire logic              s_axi_bready,    // response taken
  input  wire logic [AXI_AW-1:0] s_axi_araddr,    // read address
  input  wire logic              s_axi_arvalid,   // read addr valid
  output logic                   s_axi_arready,   // read addr taken
  output logic [AXI_DW-1:0]      s_axi_rdata,     // read data
  output logic [1:0]             s_axi_rresp,     // read response
  output logic                   s_axi_rvalid,    // read data valid
  input  wire logic              s_axi_rready,    // read data taken
  input  wire logic              event_in,        // event channel pin
  input  wire logic              companion_tick,  // companion count tick
  input  wire logic              companion_restart, // companion restart
  input  wire logic              standby_sleep,   // standby sleep level
  input  wire logic              powerdown_sleep, // power-down level
  input  wire logic              debug_halted,    // cpu halted by debug
  output logic                   compare_capture_value_out,        // compare output pin
  output logic                   event_strobe,    // event output pulse
  output logic                   irq              // interrupt request
);

  ct_ctla_t    ctla_r;
  ct_ctlb_t    ctlb_r;
  ct_evc_t     evc_r;
  logic        int_en_r;
  logic        cap_flag_r;
  logic        dbg_run_r;
  logic [7:0]  stage_r;
  logic [15:0] cnt_r;
  logic [15:0] compare_capture_value_r;
  logic        run_r;
  logic        start_pend_r;
  logic        div_r;
  logic        ev_m_r;
  logic        ev_s_r;
  logic [2:0]  hist_r;
  logic        filt_r;
  logic        lvl_prev_r;
  logic        out_r;
  logic        strobe_r;
  logic        irq_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [7:0]  rdata_r;

  // ---- bus decode: both write channels are taken together
  logic       wr_go;
  logic       rd_go;
  logic [3:0] widx;
  logic [3:0] ridx;
  logic       wr_ok;
  logic       rd_ok;
  logic [7:0] wbyte;
  logic       wr_cnt_h;
  logic       wr_ccm_h;

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
  assign rd_go = s_axi_arvalid && !arready_r && !rvalid_r;
  assign widx  = s_axi_awaddr[5:2];
  assign ridx  = s_axi_araddr[5:2];
  assign wbyte = s_axi_wdata[7:0];

  // unmapped: upper address bits, the reserved gap, or past the last index
  function automatic logic idx_ok(input logic [AXI_AW-1:0] a);
    logic [3:0] i;
    i = a[5:2];
    idx_ok = (a[AXI_AW-1:6] == '0) && (i <= IDX_CCMH) &&
             (i != 4'h2) && (i != 4'h3);
  endfunction

  assign wr_ok    = wr_go && idx_ok(s_axi_awaddr) && s_axi_wstrb[0];
  assign rd_ok    = idx_ok(s_axi_araddr);
  assign wr_cnt_h = wr_ok && (widx == IDX_CNTH);
  assign wr_ccm_h = wr_ok && (widx == IDX_CCMH);

  // ---- input pin synchroniser and noise filter on the raw system clock
  logic evt_lvl;
  logic rise;
  logic fall;
  logic trig;
  logic ss_mode;
  logic ss_trig;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_m_r <= 1'b0;
      ev_s_r <= 1'b0;
    end else begin
      ev_m_r <= event_in;
      ev_s_r <= ev_m_r;
    end
  end

  // filter never sees the prescaler, so its delay is fixed in aclk cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_r <= 3'h0;
      filt_r <= 1'b0;
    end else begin
      hist_r <= {hist_r[1:0], ev_s_r}; // RULE7
      if ({hist_r, ev_s_r} == {FILT_LEN{1'b1}})
        filt_r <= 1'b1; // RULE5 RULE6
      else if ({hist_r, ev_s_r} == {FILT_LEN{1'b0}})
        filt_r <= 1'b0; // RULE5
    end
  end

  assign evt_lvl = evc_r.filter_en ? filt_r : ev_s_r;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      lvl_prev_r <= 1'b0;
    else
      lvl_prev_r <= evt_lvl;
  end

  assign rise    = evt_lvl && !lvl_prev_r;
  assign fall    = !evt_lvl && lvl_prev_r;
  assign ss_mode = ctlb_r.timer_mode_select == M_SHOT;
  // single-shot with edge bit takes any edge, else edge bit picks polarity
  always_comb begin
    if (!evc_r.capture_event_input_enable)
      trig = 1'b0; // RULE11
    else if (ss_mode)
      trig = evc_r.edge_sel ? (rise || fall) : rise; // RULE12
    else
      trig = evc_r.edge_sel ? fall : rise; // RULE11 RULE13
  end
  assign ss_trig = ss_mode && trig && !run_r && !start_pend_r;

  // ---- count enable: sleep gating and clock source select
  logic halt;
  logic tick;

  always_comb begin
    halt = !ctla_r.enable || powerdown_sleep; // RULE17
    if (standby_sleep && !ctla_r.run_in_standby &&
        ctla_r.clock_source_select != CS_COMP)
      halt = 1'b1; // RULE18 RULE20
    if (debug_halted && !dbg_run_r)
      halt = 1'b1;
    case (ctla_r.clock_source_select)
      CS_PER:  tick = !halt; // RULE19
      CS_HALF: tick = !halt && div_r; // RULE19
      CS_COMP: tick = !halt && companion_tick; // RULE8
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      div_r <= 1'b0;
    else
      div_r <= !div_r;
  end

  // ---- counter, run state and capture register
  logic at_top;
  logic flag_set;
  logic run_nxt;

  assign at_top = tick && (cnt_r == compare_capture_value_r);

  always_comb begin
    run_nxt  = run_r;
    flag_set = 1'b0;
    if (!ctla_r.enable || halt && powerdown_sleep) begin
      run_nxt = 1'b0;
    end else if (ss_mode) begin
      if (start_pend_r)
        run_nxt = 1'b1; // RULE2
      else if (run_r && at_top) begin
        run_nxt  = 1'b0;
        flag_set = 1'b1;
      end
    end else begin
      run_nxt = 1'b1;
      if (ctlb_r.timer_mode_select == M_PERIOD)
        flag_set = at_top;
      else if (ctlb_r.timer_mode_select != M_PWM)
        flag_set = trig;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r        <= 1'b0;
      start_pend_r <= 1'b0;
    end else begin
      run_r        <= run_nxt;
      start_pend_r <= ss_trig && ctla_r.enable;
    end
  end

  // counter: bus write beats restart, restart beats counting
  always_ff @(posedge aclk) begin
    if (!aresetn)
      cnt_r <= 16'h0000;
    else if (wr_cnt_h)
      cnt_r <= {wbyte, stage_r}; // RULE22
    else if (ss_mode && start_pend_r)
      cnt_r <= 16'h0000;
    else if (ctla_r.restart_with_companion && companion_restart &&
             ctla_r.enable)
      cnt_r <= 16'h0000; // RULE9
    else if (ctlb_r.timer_mode_select == M_FREQ && trig)
      cnt_r <= 16'h0000;
    else if (tick && (!ss_mode || run_r)) begin
      if (ctlb_r.timer_mode_select == M_PWM && cnt_r[7:0] == compare_capture_value_r[7:0])
        cnt_r <= 16'h0000;
      else if (at_top && !ss_mode && ctlb_r.timer_mode_select == M_PERIOD)
        cnt_r <= 16'h0000;
      else if (!(ss_mode && at_top))
        cnt_r <= cnt_r + 16'h0001; // RULE8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      compare_capture_value_r <= 16'h0000;
    else if (wr_ccm_h)
      compare_capture_value_r <= {wbyte, stage_r}; // RULE22
    else if (trig && !ss_mode && ctlb_r.timer_mode_select != M_PERIOD &&
             ctlb_r.timer_mode_select != M_PWM)
      compare_capture_value_r <= cnt_r;
  end

  // ---- output stage
  logic out_nxt;
  logic pwm_lvl;

  // pwm: high from bottom until the high byte, period is low byte plus one
  assign pwm_lvl = (compare_capture_value_r[7:0] != 8'h00) && (cnt_r[7:0] < compare_capture_value_r[15:8]);

  always_comb begin
    if (!ctlb_r.compare_output_enable)
      out_nxt = 1'b0; // RULE21
    else if (ss_mode) begin
      // unsynced form rises on the trigger cycle, a cycle before the start
      if (ctlb_r.unsynced_output_select && ss_trig)
        out_nxt = 1'b1; // RULE1 RULE3
      else
        out_nxt = run_nxt; // RULE1 RULE2
    end else if (ctlb_r.timer_mode_select == M_PWM)
      out_nxt = pwm_lvl; // RULE4
    else
      out_nxt = ctlb_r.output_initial_level; // RULE4
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      out_r <= 1'b0;
    else
      out_r <= out_nxt;
  end

  // ---- capture flag, event strobe and interrupt request
  logic flag_clr;
  logic flag_nxt;
  logic int_en_nxt;

  assign flag_clr   = wr_ok && (widx == IDX_FLAGS) && wbyte[0];
  // a set in the clearing cycle wins, so no event is lost
  assign flag_nxt   = flag_set || (cap_flag_r && !flag_clr); // RULE14 RULE16
  assign int_en_nxt = (wr_ok && widx == IDX_INTEN) ? wbyte[0] : int_en_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_flag_r <= 1'b0;
      int_en_r   <= 1'b0;
      strobe_r   <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      cap_flag_r <= flag_nxt; // RULE14
      int_en_r   <= int_en_nxt;
      strobe_r   <= flag_set; // RULE10
      irq_r      <= flag_nxt && int_en_nxt; // RULE15 RULE16
    end
  end

  // ---- control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctla_r    <= '0;
      ctlb_r    <= '0;
      evc_r     <= '0;
      dbg_run_r <= 1'b0;
    end else if (wr_ok) begin
      if (widx == IDX_CTLA)
        ctla_r <= ct_ctla_t'(wbyte & CTLA_MASK);
      if (widx == IDX_CTLB)
        ctlb_r <= ct_ctlb_t'(wbyte & CTLB_MASK);
      if (widx == IDX_EVC)
        evc_r <= ct_evc_t'(wbyte & EVC_MASK);
      if (widx == IDX_DBG)
        dbg_run_r <= wbyte[0];
    end
  end

  // staging byte: low-byte reads latch the high half, low writes park here
  always_ff @(posedge aclk) begin
    if (!aresetn)
      stage_r <= 8'h00;
    else if (wr_ok && (widx == IDX_STAGE || widx == IDX_CNTL ||
                       widx == IDX_CCML))
      stage_r <= wbyte; // RULE22
    else if (rd_go && ridx == IDX_CNTL)
      stage_r <= cnt_r[15:8]; // RULE22
    else if (rd_go && ridx == IDX_CCML)
      stage_r <= compare_capture_value_r[15:8]; // RULE22
  end

  // ---- read mux
  logic [7:0] rbyte;

  always_comb begin
    case (ridx)
      IDX_CTLA:  rbyte = ctla_r;
      IDX_CTLB:  rbyte = ctlb_r;
      IDX_EVC:   rbyte = evc_r;
      IDX_INTEN: rbyte = {7'h00, int_en_r};
      IDX_FLAGS: rbyte = {7'h00, cap_flag_r};
      IDX_STAT:  rbyte = {7'h00, run_r};
      IDX_DBG:   rbyte = {7'h00, dbg_run_r};
      IDX_STAGE: rbyte = stage_r;
      IDX_CNTL:  rbyte = cnt_r[7:0];
      IDX_CCML:  rbyte = compare_capture_value_r[7:0];
      IDX_CNTH:  rbyte = stage_r;
      IDX_CCMH:  rbyte = stage_r;
      default:   rbyte = 8'h00;
    endcase
  end

  // ---- bus handshakes: one-cycle ready, answer raised in the same cycle as the ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      awready_r <= wr_go;
      wready_r  <= wr_go;
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= idx_ok(s_axi_awaddr) ? RESP_OKAY : RESP_SLV;
      end else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 8'h00;
    end else begin
      arready_r <= rd_go;
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLV;
        rdata_r  <= rd_ok ? rbyte : 8'h00;
      end else if (s_axi_rready)
        rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = {24'h000000, rdata_r};
  assign compare_capture_value_out      = out_r;
  assign event_strobe  = strobe_r;
  assign irq           = irq_r;

  // ---- checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_in_rise;
    evc_r.filter_en && $rose(ev_s_r) && !filt_r;
  endsequence
  sequence s_in_hold;
    (evc_r.filter_en && ev_s_r)[*3];
  endsequence

  chk_filter_delay: assert property ( // RULE5 RULE6
    s_in_rise ##1 s_in_hold |=> filt_r)
    else $error("filter did not pass level after four samples");
  chk_strobe_cause: assert property ( // RULE10
    strobe_r |-> $past(flag_set) && cap_flag_r)
    else $error("event strobe without flag set");
  chk_flag_sets: assert property ( // RULE14
    flag_set |=> cap_flag_r ##0 strobe_r)
    else $error("flag set event lost");
  chk_irq_level: assert property ( // RULE15
    irq_r == (cap_flag_r && int_en_r))
    else $error("interrupt request mismatch");
  chk_irq_holds: assert property ( // RULE16
    irq_r && !flag_clr && $stable(int_en_r) |=> irq_r)
    else $error("interrupt dropped while flag set");
  chk_out_off: assert property ( // RULE21
    !ctlb_r.compare_output_enable |=> !out_r)
    else $error("output driven while disabled");
  chk_shot_start: assert property ( // RULE2
    ss_mode && start_pend_r && ctla_r.enable &&
    ctlb_r.compare_output_enable |=> run_r && out_r)
    else $error("single-shot start not shown on output");
  chk_unsynced_output_select_rise: assert property ( // RULE3
    ss_trig && ctlb_r.compare_output_enable &&
    ctlb_r.unsynced_output_select |=> out_r ##1 run_r)
    else $error("unsynced output did not rise on trigger");
  chk_init_level: assert property ( // RULE4
    !ss_mode && ctlb_r.timer_mode_select != M_PWM &&
    ctlb_r.compare_output_enable |=> out_r == $past(ctlb_r.output_initial_level))
    else $error("output does not follow initial level");
  chk_pd_freeze: assert property ( // RULE17
    powerdown_sleep && !wr_ok |=> $stable(cnt_r) || cnt_r == 16'h0000)
    else $error("counter moved in power-down");

endmodule

// *** rtl/ct_pkg.sv ***
// package: register map, field layouts and timing for the capture timer
// assumes a byte-wide register file reached one aligned word per index
package ct_pkg;
  localparam int unsigned AXI_AW   = 8;
  localparam int unsigned AXI_DW   = 32;
  // register index; byte address is four times the index
  localparam logic [3:0] IDX_CTLA  = 4'h0;
  localparam logic [3:0] IDX_CTLB  = 4'h1;
  localparam logic [3:0] IDX_EVC   = 4'h4;
  localparam logic [3:0] IDX_INTEN = 4'h5;
  localparam logic [3:0] IDX_FLAGS = 4'h6;
  localparam logic [3:0] IDX_STAT  = 4'h7;
  localparam logic [3:0] IDX_DBG   = 4'h8;
  localparam logic [3:0] IDX_STAGE = 4'h9;
  localparam logic [3:0] IDX_CNTL  = 4'hA;
  localparam logic [3:0] IDX_CNTH  = 4'hB;
  localparam logic [3:0] IDX_CCML  = 4'hC;
  localparam logic [3:0] IDX_CCMH  = 4'hD;
  // writable bit masks, reserved bits read zero
  localparam logic [7:0] CTLA_MASK = 8'h57;
  localparam logic [7:0] CTLB_MASK = 8'h77;
  localparam logic [7:0] EVC_MASK  = 8'h51;
  localparam logic [7:0] BIT0_MASK = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;
  // clock source codes
  localparam logic [1:0] CS_PER    = 2'h0;
  localparam logic [1:0] CS_HALF   = 2'h1;
  localparam logic [1:0] CS_COMP   = 2'h2;
  // timer modes
  localparam logic [2:0] M_PERIOD  = 3'h0;
  localparam logic [2:0] M_FREQ    = 3'h3;
  localparam logic [2:0] M_SHOT    = 3'h6;
  localparam logic [2:0] M_PWM     = 3'h7;
  localparam int unsigned FILT_LEN = 4;

  typedef struct packed {
    logic       rsv7;
    logic       run_in_standby;
    logic       rsv5;
    logic       restart_with_companion;
    logic       rsv3;
    logic [1:0] clock_source_select;
    logic       enable;
  } ct_ctla_t;

  typedef struct packed {
    logic       rsv7;
    logic       unsynced_output_select;
    logic       output_initial_level;
    logic       compare_output_enable;
    logic       rsv3;
    logic [2:0] timer_mode_select;
  } ct_ctlb_t;

  typedef struct packed {
    logic       rsv7;
    logic       filter_en;
    logic       rsv5;
    logic       edge_sel;
    logic [2:0] rsv3;
    logic       capture_event_input_enable;
  } ct_evc_t;
endpackage

// *** tb/ct_far_model.sv ***
// far-side model: event channel source and companion timer tick/restart
// assumes the bench drives its requests on aclk and shares the reset
`timescale 1ns/1ps
module ct_far_model (
  input  wire logic aclk,              // system clock
  input  wire logic aresetn,           // sync reset, low
  input  wire logic tick_en,           // companion timer running
  input  wire logic restart_req,       // bench asks for a restart
  input  wire logic ev_lvl,            // wanted event line level
  output logic      event_in,          // event channel line
  output logic      companion_tick,    // companion count tick
  output logic      companion_restart  // companion counter restarted
);
  logic div_r;

  // companion counts on every other clock so ticks differ from aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r          <= 1'b0;
      companion_tick <= 1'b0;
    end else begin
      div_r          <= tick_en ? !div_r : 1'b0;
      companion_tick <= tick_en & div_r;
    end
  end

  // restart is a single-clock pulse, same domain as the timer
  always_ff @(posedge aclk) begin
    if (!aresetn) companion_restart <= 1'b0;
    else          companion_restart <= restart_req;
  end

  // registered line: any level lasts a whole clock at least
  always_ff @(posedge aclk) begin
    if (!aresetn) event_in <= 1'b0;
    else          event_in <= ev_lvl;
  end
endmodule

// *** tb/tb.sv ***
// self-checking bench for the capture timer, scenario per task
// assumes 50 MHz aclk and the far-side model driving the event/companion
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got %h expected %h", $time, a, b); end end
module tb;
  import ct_pkg::*;
  logic              aclk = 0, aresetn = 0;
  logic [AXI_AW-1:0] awaddr = 0, araddr = 0;
  logic [AXI_DW-1:0] wdata = 0, rdata;
  logic [3:0]        wstrb = 0;
  logic              awvalid = 0, wvalid = 0, bready = 0;
  logic              arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic              event_in, ctick, crst, compare_capture_value_out, event_strobe, irq;
  logic              standby = 0, pdown = 0;
  logic              tick_en = 0, rst_req = 0, ev_lvl = 0;
  logic [7:0]        d;
  logic [1:0]        r, br;
  logic [15:0]       v;
  int                num_errors = 0, checked = 0, n0, n1, n2;
  bit                mv;

  ct_capture_timer uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_in(event_in),
    .companion_tick(ctick), .companion_restart(crst),
    .standby_sleep(standby), .powerdown_sleep(pdown), .debug_halted(1'b0),
    .compare_capture_value_out(compare_capture_value_out), .event_strobe(event_strobe), .irq(irq));

  ct_far_model far (.aclk(aclk), .aresetn(aresetn), .tick_en(tick_en),
    .restart_req(rst_req), .ev_lvl(ev_lvl), .event_in(event_in),
    .companion_tick(ctick), .companion_restart(crst));

  // clock: 20 ns period
  initial begin
    forever #10 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // hang guard: whole run is about a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    end_sim();
  end

  // register write: address and data offered together, held until taken
  task automatic wr(input logic [3:0] i, input logic [7:0] dv);
    bit ad;
    bit wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr  <= {2'h0, i, 2'h0};
    wdata   <= {24'h0, dv};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // each channel is released at its own ready, in whatever order
    do begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wready === 1'b1) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end while (!(ad && wd));
    while (bvalid !== 1'b1) @(posedge aclk);
    br = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] i, output logic [7:0] dv,
                    output logic [1:0] rv);
    @(posedge aclk);
    araddr  <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    dv = rdata[7:0];
    rv = rresp;
    rready <= 1'b0;
  endtask

  // low byte first so the high byte comes from the staging latch
  task automatic rd16(input logic [3:0] i, output logic [15:0] vv);
    rd(i, vv[7:0], r);
    rd(4'(i + 1), vv[15:8], r);
  endtask

  // raise the event line, count clocks until the strobe, check its width
  task automatic ev_pulse(output int n);
    @(posedge aclk);
    ev_lvl <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end
    while (event_strobe !== 1'b1 && n < 40);
    @(posedge aclk);
    if (n < 40) `CHK(event_strobe, 1'b0)
    ev_lvl <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask

  task automatic t_regs();
    rd(IDX_CTLA, d, r);
    `CHK(d, 8'h00)
    wr(IDX_CTLA, 8'hFF);
    `CHK(br, RESP_OKAY)
    rd(IDX_CTLA, d, r);
    `CHK(d, CTLA_MASK)
    wr(IDX_CTLA, 8'h00);
    rd(4'h2, d, r);
    `CHK(r, RESP_SLV)
    wr(4'h3, 8'h00);
    `CHK(br, RESP_SLV)
    wr(IDX_CNTL, 8'h34);
    wr(IDX_CNTH, 8'h12);
    rd16(IDX_CNTL, v);
    `CHK(v, 16'h1234)
  endtask

  // output level per initial level bit and output enable, period mode only
  task automatic t_out();
    wr(IDX_CTLA, 8'h01);
    wr(IDX_CTLB, {5'h06, M_PERIOD});
    repeat (3) @(posedge aclk);
    `CHK(compare_capture_value_out, 1'b1)
    wr(IDX_CTLB, {5'h02, M_PERIOD});
    repeat (3) @(posedge aclk);
    `CHK(compare_capture_value_out, 1'b0)
    wr(IDX_CTLB, {5'h04, M_PERIOD});
    repeat (3) @(posedge aclk);
    `CHK(compare_capture_value_out, 1'b0)
  endtask

  task automatic t_event();
    wr(IDX_CTLB, {5'h00, M_FREQ});
    wr(IDX_EVC, 8'h00);
    ev_pulse(n0);
    rd(IDX_FLAGS, d, r);
    `CHK(d, 8'h00)
    wr(IDX_EVC, 8'h01);
    ev_pulse(n0);
    rd(IDX_FLAGS, d, r);
    `CHK(d, 8'h01)
    `CHK(irq, 1'b0)
    wr(IDX_INTEN, 8'h01);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    repeat (10) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(IDX_FLAGS, 8'h01);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
  endtask

  // filter latency relative to the unfiltered path
  task automatic t_filter();
    ev_pulse(n0);
    wr(IDX_FLAGS, 8'h01);
    wr(IDX_EVC, 8'h41);
    ev_pulse(n1);
    wr(IDX_FLAGS, 8'h01);
    `CHK(n1, n0 + 4)
    wr(IDX_CTLA, 8'h03);
    ev_pulse(n2);
    wr(IDX_FLAGS, 8'h01);
    `CHK(n2, n1)
    // two-clock glitch must not pass four equal samples
    @(posedge aclk);
    ev_lvl <= 1'b1;
    repeat (2) @(posedge aclk);
    ev_lvl <= 1'b0;
    repeat (15) @(posedge aclk);
    rd(IDX_FLAGS, d, r);
    `CHK(d, 8'h00)
  endtask

  task automatic t_shot(input logic as, output int n);
    int m;
    wr(IDX_CTLA, 8'h00);
    wr(IDX_EVC, 8'h01);
    wr(IDX_CCML, 8'h03);
    wr(IDX_CCMH, 8'h00);
    wr(IDX_CTLB, {1'b0, as, 3'h2, M_SHOT});
    wr(IDX_CTLA, 8'h01);
    repeat (30) @(posedge aclk);
    wr(IDX_FLAGS, 8'h01);
    `CHK(compare_capture_value_out, 1'b0)
    @(posedge aclk);
    ev_lvl <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end
    while (compare_capture_value_out !== 1'b1 && n < 40);
    m = 0;
    do begin @(posedge aclk); m++; end
    while (compare_capture_value_out !== 1'b0 && m < 60);
    ev_lvl <= 1'b0;
    rd(IDX_FLAGS, d, r);
    `CHK(d, 8'h01)
  endtask

  // companion clock: no ticks, no progress; ticks resume, shot ends
  task automatic t_comp();
    wr(IDX_CTLA, 8'h05);
    wr(IDX_FLAGS, 8'h01);
    ev_pulse(n0);
    repeat (30) @(posedge aclk);
    `CHK(irq, 1'b0)
    tick_en <= 1'b1;
    n0 = 0;
    do begin @(posedge aclk); n0++; end
    while (irq !== 1'b1 && n0 < 60);
    `CHK(irq, 1'b1)
  endtask

  task automatic moved(output bit m);
    logic [15:0] a;
    rd16(IDX_CNTL, a);
    repeat (10) @(posedge aclk);
    rd16(IDX_CNTL, v);
    m = (a !== v);
  endtask

  task automatic t_sleep();
    wr(IDX_CTLB, {5'h00, M_PERIOD});
    wr(IDX_CCML, 8'hFF);
    wr(IDX_CCMH, 8'hFF);
    wr(IDX_CTLA, 8'h01);
    pdown <= 1'b1;
    moved(mv);
    `CHK(mv, 1'b0)
    pdown   <= 1'b0;
    standby <= 1'b1;
    moved(mv);
    `CHK(mv, 1'b0)
    wr(IDX_CTLA, 8'h41);
    moved(mv);
    `CHK(mv, 1'b1)
    wr(IDX_CTLA, 8'h05);
    moved(mv);
    `CHK(mv, 1'b1)
    standby <= 1'b0;
  endtask

  task automatic t_restart(input logic [7:0] ctla, input bit near0);
    wr(IDX_CTLA, ctla);
    repeat (100) @(posedge aclk);
    rst_req <= 1'b1;
    @(posedge aclk);
    rst_req <= 1'b0;
    rd16(IDX_CNTL, v);
    `CHK(v < 16'd20, near0)
  endtask

  // pwm: period is low byte plus one, high for high-byte cycles
  task automatic t_pwm();
    int h;
    wr(IDX_CTLA, 8'h00);
    wr(IDX_CCML, 8'h03);
    wr(IDX_CCMH, 8'h01);
    wr(IDX_CNTL, 8'h00);
    wr(IDX_CNTH, 8'h00);
    wr(IDX_CTLB, {5'h02, M_PWM});
    wr(IDX_CTLA, 8'h01);
    h = 0;
    repeat (8) begin
      @(posedge aclk);
      if (compare_capture_value_out === 1'b1)
        h++;
    end
    `CHK(h, 2)
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(irq, 1'b0)
    `CHK(compare_capture_value_out, 1'b0)
    t_regs();
    t_out();
    t_event();
    t_filter();
    t_shot(1'b0, n0);
    t_shot(1'b1, n1);
    `CHK(n1, n0 - 1)
    t_comp();
    t_sleep();
    t_restart(8'h01, 1'b0);
    t_restart(8'h11, 1'b1);
    t_pwm();
    end_sim();
  end
endmodule
